// file: bench/cksu_ref_model.sv
// Model of the two reference sources feeding the sequencer and selector
`timescale 1ns/1ps
module cksu_ref_model
(
  input wire logic clk_i,
  input wire logic tick_en_i,
  input wire logic clr_i,
  input wire logic pri_on_i,
  output logic ref_tick_o,
  output logic feedback_tick_o,
  output logic primary_present_o,
  output logic secondary_present_o,
  output logic [15:0] ticks_o
);
  logic [1:0] phase;

  // One tick every fourth cycle; phase restarts so no tick hits the hold cycle
  always_ff @(posedge clk_i)
  begin
    phase <= tick_en_i ? phase + 2'h1 : 2'h0;
    ref_tick_o <= tick_en_i && phase == 2'h3;
  end

  // Feedback path runs locked to the reference, so both counts share one tally
  assign feedback_tick_o = ref_tick_o;

  // Tally of ticks the sequencer has sampled
  always_ff @(posedge clk_i)
  begin
    if (clr_i)
      ticks_o <= 16'h0000;
    else if (ref_tick_o)
      ticks_o <= ticks_o + 16'h0001;
  end

  // Secondary always present; primary drops out on command
  assign primary_present_o = pri_on_i;
  assign secondary_present_o = 1'b1;
endmodule // cksu_ref_model

// file: bench/test_cksu_top.sv
// Self-checking bench of the clock start-up sequencer and reference selector
`timescale 1ns/1ps
module test_cksu_top
  import cksu_pkg::*;
;
  localparam int REF = 8;
  localparam int FB = 8;
  localparam int CAL = 16;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic active_low_reset_i = 1'b1;
  logic power_down_pin_n_i = 1'b1;
  logic ce_i = 1'b1;
  logic interface_mode_pin_i = 1'b0;
  logic ref_select_pin_i = 1'b0;
  logic pin_config_auto_i = 1'b0;
  logic xtal_used_i = 1'b0;
  logic xtal_swing_ok_i = 1'b1;
  logic tick_en = 1'b0;
  logic tick_clr = 1'b1;
  logic pri_on = 1'b1;
  logic sel_watch = 1'b0;
  logic [31:0] wb_dat_o, rd;
  logic [15:0] ticks;
  logic wb_ack_o, outputs_enable_o, status_output_zero_o, status_output_one_o;
  logic primary_gate_o, secondary_gate_o, irq_o;
  logic primary_present_i, secondary_present_i, ref_tick_i, feedback_tick_i;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;

  cksu_top #(.REF_CYCLES(REF), .FB_CYCLES(FB), .CAL_CYCLES(CAL)) cksu_top_inst (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .active_low_reset_i, .power_down_pin_n_i,
    .interface_mode_pin_i, .ref_select_pin_i, .pin_config_auto_i, .xtal_used_i,
    .xtal_swing_ok_i, .primary_present_i, .secondary_present_i, .ref_tick_i,
    .feedback_tick_i, .outputs_enable_o, .status_output_zero_o, .status_output_one_o,
    .primary_gate_o, .secondary_gate_o, .irq_o);

  cksu_ref_model cksu_ref_model_inst (.clk_i, .tick_en_i(tick_en), .clr_i(tick_clr),
    .pri_on_i(pri_on), .ref_tick_o(ref_tick_i), .feedback_tick_o(feedback_tick_i),
    .primary_present_o(primary_present_i), .secondary_present_o(secondary_present_i),
    .ticks_o(ticks));

  // Free-running 10 MHz clock
  initial
  begin
    forever #50 clk_i = ~clk_i;
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({31'h0, got}, {31'h0, exp});
  endtask

  task automatic chk_in(input logic [31:0] got, input int lo, input int hi);
    samples_checked++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      failures++;
      $display("wrong value at %0t: %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask

  // Classic single Wishbone cycle; request held until ack is sampled
  task automatic wb_rw(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                       output logic [31:0] rdv);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rdv = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  // Hold by one reset source, tick meanwhile, release, count ticks to outputs on
  task automatic startup(input int kind, input logic [31:0] exp_ctrl);
    @(posedge clk_i);
    tick_en <= 1'b0;
    tick_clr <= 1'b1;
    if (kind == 0)
      rst_i <= 1'b1;
    if (kind == 1)
      wb_rw(1'b1, ADR_CTRL, 32'h0000_0009, rd);
    if (kind == 2)
      xtal_used_i <= 1'b1;
    if (kind == 2)
      xtal_swing_ok_i <= 1'b0;
    if (kind == 3)
      active_low_reset_i <= 1'b0;
    if (kind == 4)
      power_down_pin_n_i <= 1'b0;
    repeat (6) @(posedge clk_i);
    tick_en <= 1'b1;
    repeat (40) @(posedge clk_i);
    chk_bit(outputs_enable_o, 1'b0);
    tick_en <= 1'b0;
    rst_i <= 1'b0;
    xtal_swing_ok_i <= 1'b1;
    active_low_reset_i <= 1'b1;
    power_down_pin_n_i <= 1'b1;
    if (kind == 1)
      wb_rw(1'b1, ADR_CTRL, 32'h0000_0001, rd);
    repeat (3) @(posedge clk_i);
    tick_clr <= 1'b0;
    tick_en <= 1'b1;
    repeat (400) if (outputs_enable_o !== 1'b1) @(posedge clk_i);
    @(negedge clk_i);
    chk_word({16'h0, ticks}, REF + FB + CAL);
    wb_rw(1'b0, ADR_CTRL, 32'h0, rd);
    chk_word(rd, exp_ctrl);
  endtask

  // Lock rise timing, routing, and the interrupt raised, masked and cleared
  task automatic lock_check();
    wb_rw(1'b1, ADR_IRQ_ENABLE, 32'h0000_0002, rd);
    @(negedge clk_i);
    chk_bit(irq_o, 1'b0);
    repeat (12000) if (status_output_zero_o !== 1'b1) @(posedge clk_i);
    @(negedge clk_i);
    chk_in({16'h0, ticks - 16'd32}, LOCK_MIN_CYCLES, LOCK_MAX_CYCLES);
    chk_bit(status_output_one_o, 1'b0);
    chk_bit(irq_o, 1'b1);
    wb_rw(1'b1, ADR_IRQ_ENABLE, 32'h0, rd);
    @(negedge clk_i);
    chk_bit(irq_o, 1'b0);
    wb_rw(1'b1, ADR_IRQ_ENABLE, 32'h0000_0002, rd);
    @(negedge clk_i);
    chk_bit(irq_o, 1'b1);
    wb_rw(1'b1, ADR_IRQ_CLEAR, 32'h0000_0002, rd);
    @(negedge clk_i);
    chk_bit(irq_o, 1'b0);
  endtask

  // Apply one selector setting, let any guard time pass, judge the gates
  task automatic sel_case(input logic mode, input logic [31:0] ctrl, input logic pin,
                          input logic auto_cfg, input logic pri, input logic exp_sec);
    interface_mode_pin_i <= mode;
    ref_select_pin_i <= pin;
    pin_config_auto_i <= auto_cfg;
    pri_on <= pri;
    wb_rw(1'b1, ADR_CTRL, ctrl, rd);
    repeat (300) if ((exp_sec ? secondary_gate_o : primary_gate_o) !== 1'b1) @(posedge clk_i);
    repeat (40) @(posedge clk_i);
    chk_bit(secondary_gate_o, exp_sec);
    chk_bit(primary_gate_o, !exp_sec);
  endtask

  // Clock enable low stalls the bus answer; status read back once it runs again
  task automatic ce_freeze();
    @(posedge clk_i);
    ce_i <= 1'b0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= 1'b0;
    wb_adr_i <= ADR_STATUS;
    repeat (8) @(posedge clk_i);
    chk_bit(wb_ack_o, 1'b0);
    ce_i <= 1'b1;
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    chk_word(rd, 32'h0000_0003);
  endtask

  // Both gates open at once would pass a runt edge
  always @(negedge clk_i)
    if (sel_watch)
      chk_bit(primary_gate_o & secondary_gate_o, 1'b0);

  // Hang guard
  always @(posedge clk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 40000)
    begin
      failures++;
      tally_and_finish();
    end
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    startup(0, 32'h0);
    sel_watch = 1'b1;
    wb_rw(1'b1, 8'h40, 32'hffff_ffff, rd);
    wb_rw(1'b0, 8'h40, 32'h0, rd);
    chk_word(rd, 32'h0);
    startup(1, 32'h0000_0001);
    lock_check();
    ce_freeze();
    startup(2, 32'h0000_0001);
    sel_case(1'b0, 32'h0000_0000, 1'b1, 1'b0, 1'b1, 1'b0);
    sel_case(1'b0, 32'h0000_1000, 1'b0, 1'b0, 1'b0, 1'b1);
    wb_rw(1'b0, ADR_IRQ_STATUS, 32'h0, rd);
    chk_word(rd & 32'h0000_000c, 32'h0000_000c);
    sel_case(1'b0, 32'h0000_0000, 1'b0, 1'b0, 1'b1, 1'b0);
    sel_case(1'b0, 32'h0000_2000, 1'b1, 1'b0, 1'b0, 1'b0);
    sel_case(1'b0, 32'h0000_3000, 1'b1, 1'b0, 1'b1, 1'b1);
    sel_case(1'b0, 32'h0000_3000, 1'b0, 1'b0, 1'b1, 1'b0);
    sel_case(1'b1, 32'h0000_2000, 1'b1, 1'b0, 1'b1, 1'b1);
    sel_case(1'b1, 32'h0000_0000, 1'b0, 1'b0, 1'b0, 1'b0);
    sel_case(1'b1, 32'h0000_0000, 1'b0, 1'b1, 1'b0, 1'b1);
    startup(3, 32'h0);
    startup(4, 32'h0);
    tally_and_finish();
  end
endmodule // test_cksu_top

// file: design/cksu_glitch_sel.sv
// Glitch-free reference switch: both gates closed for a guard time
`timescale 1ns/1ps
module cksu_glitch_sel
  import cksu_pkg::*;
#(
  parameter int unsigned GUARD = GUARD_TICKS
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic tick_i,
  input wire logic want_sec_i,
  output logic pri_en_o,
  output logic sec_en_o,
  output logic sel_sec_o,
  output logic switching_o,
  output logic done_o
);

  localparam logic [GUARD_CNT_W-1:0] GUARD_LAST = GUARD_CNT_W'(GUARD - 1);

  logic [GUARD_CNT_W-1:0] guard_cnt;

  // Break before make, so no runt pulse reaches the detector
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      sel_sec_o <= 1'b0;
      switching_o <= 1'b0;
      guard_cnt <= '0;
      done_o <= 1'b0;
    end
    else if (ce_i)
    begin
      done_o <= 1'b0;
      if (!switching_o)
      begin
        if (want_sec_i != sel_sec_o)
        begin
          switching_o <= 1'b1;
          guard_cnt <= '0;
        end
      end
      else if (tick_i)
      begin
        if (guard_cnt == GUARD_LAST)
        begin
          // Target is sampled at the end, so a bounce back just reopens the old gate
          sel_sec_o <= want_sec_i;
          switching_o <= 1'b0;
          done_o <= (want_sec_i != sel_sec_o);
        end
        else
        begin
          guard_cnt <= guard_cnt + 1'b1;
        end
      end
    end
  end

  // Gates derived from flops only
  assign pri_en_o = !switching_o && !sel_sec_o;
  assign sec_en_o = !switching_o && sel_sec_o;

  chk_one_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !(pri_en_o && sec_en_o))
    else $error("both reference gates open");

  chk_sel_guarded: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(sel_sec_o) |-> $past(switching_o) && !$past(pri_en_o) && !$past(sec_en_o))
    else $error("reference changed without guard");

endmodule // cksu_glitch_sel

// file: design/cksu_top.sv
// Start-up sequencer, reference selector and register slave of a clock generator
// How it works
// - After reset release count 64k reference cycles before anything else.
// - Then count 64k feedback cycles so internal counters settle.
// - Then calibrate the oscillator for exactly 128k reference cycles.
// - Outputs stay off during start-up, turn on right after calibration.
// - Routed lock indicator rises 2048 to 2560 reference cycles after calibration.
// - Serial mode, manual bit clear: automatic choice, primary first.
// - Serial mode, select bits 10: primary forced, select pin ignored.
// - Serial mode, select bits 11: select pin picks, low primary.
// - Pin mode: register bits ignored, pin picks primary/secondary or auto.
// - Switching between references never lets a glitch through.
// - With a crystal, stay in reset until its swing is adequate.
// - Restart bit high then low reruns start-up, keeping register values.
//
// The register offsets and register access over Wishbone were left to the implementer.
`timescale 1ns/1ps
module cksu_top
  import cksu_pkg::*;
#(
  parameter int unsigned REF_CYCLES = REF_COUNT_CYCLES,
  parameter int unsigned FB_CYCLES = FB_COUNT_CYCLES,
  parameter int unsigned CAL_CYCLES = CAL_COUNT_CYCLES,
  parameter int unsigned LOCK_CYCLES = LOCK_DELAY_CYCLES
)
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic active_low_reset_i,
  input wire logic power_down_pin_n_i,
  input wire logic interface_mode_pin_i,
  input wire logic ref_select_pin_i,
  input wire logic pin_config_auto_i,
  input wire logic xtal_used_i,
  input wire logic xtal_swing_ok_i,
  input wire logic primary_present_i,
  input wire logic secondary_present_i,
  input wire logic ref_tick_i,
  input wire logic feedback_tick_i,
  output logic outputs_enable_o,
  output logic status_output_zero_o,
  output logic status_output_one_o,
  output logic primary_gate_o,
  output logic secondary_gate_o,
  output logic irq_o
);

  localparam logic [STEP_CNT_W-1:0] REF_LAST = STEP_CNT_W'(REF_CYCLES - 1);
  localparam logic [STEP_CNT_W-1:0] FB_LAST = STEP_CNT_W'(FB_CYCLES - 1);
  localparam logic [STEP_CNT_W-1:0] CAL_LAST = STEP_CNT_W'(CAL_CYCLES - 1);
  localparam logic [LOCK_CNT_W-1:0] LOCK_LAST = LOCK_CNT_W'(LOCK_CYCLES - 1);
  localparam int LOCK_MIN_I = LOCK_MIN_CYCLES;
  localparam int LOCK_MAX_I = LOCK_MAX_CYCLES;

  cksu_state_t state;
  cksu_ctrl_t ctrl;
  logic [STEP_CNT_W-1:0] step_cnt;
  logic [LOCK_CNT_W-1:0] lock_cnt;
  logic locked;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_enable;
  logic [IRQ_W-1:0] events;
  logic primary_seen;
  logic pin_reset;
  logic seq_reset;
  logic cal_end;
  logic lock_set;
  logic auto_sec;
  logic want_sec;
  logic sel_sec;
  logic switching;
  logic switch_done;
  logic bus_req;
  logic bus_commit;
  logic [31:0] read_word;

  // Pin resets reload defaults; the register restart only reruns the sequence
  assign pin_reset = !active_low_reset_i || !power_down_pin_n_i;
  assign seq_reset = pin_reset || ctrl.restart
    || (xtal_used_i && !xtal_swing_ok_i);

  assign cal_end = ce_i && (state == ST_CALIBRATE) && ref_tick_i && (step_cnt == CAL_LAST);

  // Start-up step sequencer
  always_ff @(posedge clk_i)
  begin
    if (rst_i || seq_reset)
    begin
      state <= ST_HOLD;
      step_cnt <= '0;
    end
    else if (ce_i)
    begin
      unique case (state)
        ST_HOLD:
        begin
          state <= ST_REF_COUNT;
          step_cnt <= '0;
        end
        ST_REF_COUNT:
        begin
          if (ref_tick_i)
          begin
            if (step_cnt == REF_LAST)
            begin
              state <= ST_FB_COUNT;
              step_cnt <= '0;
            end
            else
            begin
              step_cnt <= step_cnt + 1'b1;
            end
          end
        end
        ST_FB_COUNT:
        begin
          if (feedback_tick_i)
          begin
            if (step_cnt == FB_LAST)
            begin
              state <= ST_CALIBRATE;
              step_cnt <= '0;
            end
            else
            begin
              step_cnt <= step_cnt + 1'b1;
            end
          end
        end
        ST_CALIBRATE:
        begin
          if (ref_tick_i)
          begin
            if (step_cnt == CAL_LAST)
            begin
              state <= ST_RUN;
            end
            else
            begin
              step_cnt <= step_cnt + 1'b1;
            end
          end
        end
        ST_RUN:
        begin
          state <= ST_RUN;
        end
      endcase
    end
  end

  // Output enable follows the calibration end by one cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || seq_reset)
    begin
      outputs_enable_o <= 1'b0;
    end
    else if (ce_i && cal_end)
    begin
      outputs_enable_o <= 1'b1;
    end
  end

  // Lock delay counts reference cycles after calibration; loop is not monitored
  assign lock_set = ce_i && outputs_enable_o && !locked && ref_tick_i && (lock_cnt == LOCK_LAST);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || seq_reset)
    begin
      lock_cnt <= '0;
      locked <= 1'b0;
    end
    else if (ce_i && outputs_enable_o && !locked && ref_tick_i)
    begin
      if (lock_cnt == LOCK_LAST)
      begin
        locked <= 1'b1;
      end
      else
      begin
        lock_cnt <= lock_cnt + 1'b1;
      end
    end
  end

  // Status pins carry lock only where routed
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      status_output_zero_o <= 1'b0;
      status_output_one_o <= 1'b0;
    end
    else if (ce_i)
    begin
      status_output_zero_o <= ctrl.route0 && (locked || lock_set);
      status_output_one_o <= ctrl.route1 && (locked || lock_set);
    end
  end

  // Reference choice; secondary also absent means stay on primary
  assign auto_sec = !primary_present_i && secondary_present_i;

  always_comb
  begin
    want_sec = 1'b0;
    if (interface_mode_pin_i)
    begin
      if (pin_config_auto_i)
      begin
        want_sec = auto_sec;
      end
      else
      begin
        want_sec = ref_select_pin_i;
      end
    end
    else if (!ctrl.manual)
    begin
      want_sec = auto_sec;
    end
    else if (!ctrl.choice)
    begin
      want_sec = 1'b0;
    end
    else
    begin
      want_sec = ref_select_pin_i;
    end
  end

  cksu_glitch_sel #(
    .GUARD(GUARD_TICKS)
  ) cksu_glitch_sel_inst (
    .clk_i(clk_i),
    .rst_i(rst_i || pin_reset),
    .ce_i(ce_i),
    .tick_i(ref_tick_i),
    .want_sec_i(want_sec),
    .pri_en_o(primary_gate_o),
    .sec_en_o(secondary_gate_o),
    .sel_sec_o(sel_sec),
    .switching_o(switching),
    .done_o(switch_done)
  );

  // Primary loss edge for the interrupt
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      primary_seen <= 1'b0;
    end
    else if (ce_i)
    begin
      primary_seen <= primary_present_i;
    end
  end

  always_comb
  begin
    events = '0;
    events[IRQ_CAL_DONE] = cal_end;
    events[IRQ_LOCKED] = lock_set;
    events[IRQ_SWITCHED] = ce_i && switch_done;
    events[IRQ_PRI_LOST] = ce_i && primary_seen && !primary_present_i;
  end

  // Wishbone classic: registered ack one cycle after the strobe
  assign bus_req = wb_cyc_i && wb_stb_i;
  assign bus_commit = bus_req && wb_we_i && wb_ack_o && ce_i;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_ack_o <= 1'b0;
    end
    else if (ce_i)
    begin
      wb_ack_o <= bus_req && !wb_ack_o;
    end
  end

  always_comb
  begin
    read_word = 32'h0000_0000;
    unique case (wb_adr_i)
      ADR_CTRL:
      begin
        read_word[CTRL_ROUTE0_BIT] = ctrl.route0;
        read_word[CTRL_ROUTE1_BIT] = ctrl.route1;
        read_word[CTRL_RESTART_BIT] = ctrl.restart;
        read_word[CTRL_CHOICE_BIT] = ctrl.choice;
        read_word[CTRL_MANUAL_BIT] = ctrl.manual;
      end
      ADR_STATUS:
      begin
        read_word[STAT_OUT_ON_BIT] = outputs_enable_o;
        read_word[STAT_LOCKED_BIT] = locked;
        read_word[STAT_CAL_BIT] = (state == ST_CALIBRATE);
        read_word[STAT_SEC_BIT] = sel_sec;
        read_word[STAT_SWITCH_BIT] = switching;
        read_word[STAT_HOLD_BIT] = (state == ST_HOLD);
        read_word[STAT_MODE_BIT] = interface_mode_pin_i;
      end
      ADR_IRQ_STATUS:
      begin
        read_word[IRQ_W-1:0] = irq_status;
      end
      ADR_IRQ_ENABLE:
      begin
        read_word[IRQ_W-1:0] = irq_enable;
      end
      default:
      begin
        read_word = 32'h0000_0000; // Unmapped and write-only read as zero
      end
    endcase
  end

  // Read data captured as ack rises
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      wb_dat_o <= 32'h0000_0000;
    end
    else if (ce_i && bus_req && !wb_ack_o)
    begin
      wb_dat_o <= read_word;
    end
  end

  // Control register: defaults only from pin or bus reset
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pin_reset)
    begin
      ctrl <= CTRL_RESET;
      irq_enable <= IRQ_RESET;
    end
    else if (bus_commit && wb_adr_i == ADR_CTRL)
    begin
      if (wb_sel_i[0])
      begin
        ctrl.route0 <= wb_dat_i[CTRL_ROUTE0_BIT];
        ctrl.route1 <= wb_dat_i[CTRL_ROUTE1_BIT];
        ctrl.restart <= wb_dat_i[CTRL_RESTART_BIT];
      end
      if (wb_sel_i[1])
      begin
        ctrl.choice <= wb_dat_i[CTRL_CHOICE_BIT];
        ctrl.manual <= wb_dat_i[CTRL_MANUAL_BIT];
      end
    end
    else if (bus_commit && wb_adr_i == ADR_IRQ_ENABLE && wb_sel_i[0])
    begin
      irq_enable <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Sticky events; a new event wins over a clear in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i || pin_reset)
    begin
      irq_status <= IRQ_RESET;
    end
    else if (ce_i)
    begin
      if (bus_commit && wb_adr_i == ADR_IRQ_CLEAR && wb_sel_i[0])
      begin
        irq_status <= (irq_status & ~wb_dat_i[IRQ_W-1:0]) | events;
      end
      else
      begin
        irq_status <= irq_status | events;
      end
    end
  end

  assign irq_o = |(irq_status & irq_enable);

  sequence s_cal_end;
    cal_end;
  endsequence

  sequence s_outputs_on;
    outputs_enable_o && state == ST_RUN;
  endsequence

  chk_ref_first: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ST_FB_COUNT) |-> $past(state) == ST_REF_COUNT && $past(step_cnt) == REF_LAST)
    else $error("feedback count began early");

  chk_fb_second: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ST_CALIBRATE) |-> $past(state) == ST_FB_COUNT && $past(step_cnt) == FB_LAST)
    else $error("calibration began early");

  chk_cal_length: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(state == ST_RUN) |-> $past(state) == ST_CALIBRATE && $past(step_cnt) == CAL_LAST)
    else $error("calibration length wrong");

  chk_outputs_on: assert property (@(posedge clk_i) disable iff (rst_i || seq_reset)
    s_cal_end |=> s_outputs_on)
    else $error("outputs not enabled after calibration");

  chk_outputs_off: assert property (@(posedge clk_i) disable iff (rst_i)
    state != ST_RUN |-> !outputs_enable_o)
    else $error("outputs on during start-up");

  chk_lock_window: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(locked) |-> (int'(lock_cnt) + 1 >= LOCK_MIN_I) && (int'(lock_cnt) + 1 <= LOCK_MAX_I))
    else $error("lock outside window");

  chk_auto_pri: assert property (@(posedge clk_i) disable iff (rst_i)
    !interface_mode_pin_i && !ctrl.manual && primary_present_i |-> !want_sec)
    else $error("auto mode left primary");

  chk_force_pri: assert property (@(posedge clk_i) disable iff (rst_i)
    !interface_mode_pin_i && ctrl.manual && !ctrl.choice |-> !want_sec)
    else $error("forced primary not honoured");

  chk_pin_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    !interface_mode_pin_i && ctrl.manual && ctrl.choice |-> want_sec == ref_select_pin_i)
    else $error("select pin not followed");

  chk_pin_mode: assert property (@(posedge clk_i) disable iff (rst_i)
    interface_mode_pin_i && !pin_config_auto_i |-> want_sec == ref_select_pin_i)
    else $error("pin mode choice wrong");

  chk_xtal_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    xtal_used_i && !xtal_swing_ok_i |=> state == ST_HOLD && !outputs_enable_o)
    else $error("started without crystal swing");

  chk_restart_keep: assert property (@(posedge clk_i) disable iff (rst_i || pin_reset)
    ctrl.restart |=> state == ST_HOLD && $stable(irq_enable))
    else $error("restart not rerunning start-up");

  chk_auto_sec: assert property (@(posedge clk_i) disable iff (rst_i)
    !interface_mode_pin_i && !ctrl.manual && !primary_present_i && secondary_present_i
    |-> want_sec)
    else $error("auto mode ignored primary loss");

endmodule // cksu_top

// file: include/cksu_pkg.sv
// Shared constants, types and register map of the clock start-up sequencer
package cksu_pkg;

  // Start-up step lengths, counted in phase-detector or feedback cycles
  localparam int unsigned REF_COUNT_CYCLES = 65536;
  localparam int unsigned FB_COUNT_CYCLES = 65536;
  localparam int unsigned CAL_COUNT_CYCLES = 131072;
  localparam int unsigned LOCK_DELAY_CYCLES = 2305;
  localparam int unsigned LOCK_MIN_CYCLES = 2048;
  localparam int unsigned LOCK_MAX_CYCLES = 2560;
  localparam int unsigned GUARD_TICKS = 4;
  localparam int unsigned STEP_CNT_W = 18;
  localparam int unsigned LOCK_CNT_W = 12;
  localparam int unsigned GUARD_CNT_W = 4;

  // Register byte offsets
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_IRQ_STATUS = 8'h08;
  localparam logic [7:0] ADR_IRQ_CLEAR = 8'h0c;
  localparam logic [7:0] ADR_IRQ_ENABLE = 8'h10;

  // Control register field positions
  localparam int unsigned CTRL_ROUTE0_BIT = 0;
  localparam int unsigned CTRL_ROUTE1_BIT = 1;
  localparam int unsigned CTRL_RESTART_BIT = 3;
  localparam int unsigned CTRL_CHOICE_BIT = 12;
  localparam int unsigned CTRL_MANUAL_BIT = 13;

  // Status register field positions
  localparam int unsigned STAT_OUT_ON_BIT = 0;
  localparam int unsigned STAT_LOCKED_BIT = 1;
  localparam int unsigned STAT_CAL_BIT = 2;
  localparam int unsigned STAT_SEC_BIT = 3;
  localparam int unsigned STAT_SWITCH_BIT = 4;
  localparam int unsigned STAT_HOLD_BIT = 5;
  localparam int unsigned STAT_MODE_BIT = 8;

  // Interrupt event positions
  localparam int unsigned IRQ_W = 4;
  localparam int unsigned IRQ_CAL_DONE = 0;
  localparam int unsigned IRQ_LOCKED = 1;
  localparam int unsigned IRQ_SWITCHED = 2;
  localparam int unsigned IRQ_PRI_LOST = 3;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_RESET = 4'h0;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_REF_COUNT,
    ST_FB_COUNT,
    ST_CALIBRATE,
    ST_RUN
  } cksu_state_t;

  typedef struct packed {
    logic manual;
    logic choice;
    logic restart;
    logic route1;
    logic route0;
  } cksu_ctrl_t;

  localparam cksu_ctrl_t CTRL_RESET = 5'h00;

endpackage
